// ---- core/vfmc_map.vh ----
// Register map and field positions for the video forwarding mode control block.
// Assumes an AHB-Lite slave with one 32-bit word per register.
`ifndef VFMC_MAP_VH
`define VFMC_MAP_VH
// Register indices; byte address is four times the index
`define VFMC_IDX_FWD_SELECT   8'h20
`define VFMC_IDX_MODE_CTRL    8'h21
`define VFMC_IDX_FWD_STATUS   8'h22
`define VFMC_IDX_IRQ_STATUS   8'h23
`define VFMC_IDX_IRQ_ENABLE   8'h24
`define VFMC_IDX_IRQ_CLEAR    8'h25
// Reset values
`define VFMC_RST_FWD_SELECT   8'hf0
`define VFMC_RST_MODE_CTRL    8'h03
// Mode control fields
`define VFMC_BIT_REPLICATE    7
`define VFMC_BIT_SEND_READY   6
`define VFMC_OUT1_SYNC_HI     5
`define VFMC_OUT1_SYNC_LO     4
`define VFMC_OUT0_SYNC_HI     3
`define VFMC_OUT0_SYNC_LO     2
`define VFMC_BIT_OUT1_RR      1
`define VFMC_BIT_OUT0_RR      0
// Sync mode encodings
`define VFMC_SYNC_OFF         2'h0
`define VFMC_SYNC_BASIC       2'h1
`define VFMC_SYNC_INTERLEAVE  2'h2
`define VFMC_SYNC_CONCAT      2'h3
// Forward select fields: disables at 7:4, output select at 3:0
`define VFMC_FWD_DIS_LO       4
`endif

// ---- core/vfmc_forward_ctrl.v ----
// Forwarding mode control: register file and per-output forwarding engines, four receive ports, two outputs.
// Assumes each receive buffer presents line_avail/line_is_sync and accepts line_take; outputs ack each send.
`timescale 1ns/10ps
`include "vfmc_map.vh"
module vfmc_forward_ctrl #(
  parameter NPORT = 4,
  parameter DW    = 32
) (
  // Clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire [31:0]       hrdata,
  output wire              hreadyout,
  output wire              hresp,
  // Receive port buffers
  input  wire [NPORT-1:0]  line_avail,
  input  wire [NPORT-1:0]  line_is_sync,
  input  wire [NPORT*DW-1:0] line_data,
  output reg  [NPORT-1:0]  line_take,
  // Output ports
  output reg  [1:0]        out_valid,
  output reg  [1:0]        out_first,
  output reg  [1:0]        out_last,
  output reg  [2*DW-1:0]   out_data,
  input  wire [1:0]        out_ack,
  input  wire [1:0]        frame_end,
  // Interrupt
  output wire              irq
);

  reg  [7:0]       fwd_select;
  reg  [7:0]       forwarding_mode_control;
  reg  [1:0]       out_sync_failure_flag;
  reg  [1:0]       out_sync_locked;
  reg  [1:0]       frame_good;
  reg  [3:0]       irq_status;
  reg  [3:0]       irq_enable;
  reg              dph_write;
  reg              dph_read;
  reg  [7:0]       dph_idx;
  reg  [7:0]       rd_word;
  reg  [7:0]       rd_hold;
  reg  [1:0]       rr_ptr [0:1];
  reg  [1:0]       cur_port [0:1];
  reg  [1:0]       busy;
  reg  [3:0]       pend [0:1];
  reg  [3:0]       sent_mask [0:1];
  reg  [1:0]       g_out_lock_q;

  wire       replicate  = forwarding_mode_control[`VFMC_BIT_REPLICATE];
  wire       send_ready = forwarding_mode_control[`VFMC_BIT_SEND_READY];
  wire [1:0] sync_mode0 = forwarding_mode_control[`VFMC_OUT0_SYNC_HI:`VFMC_OUT0_SYNC_LO];
  wire [1:0] sync_mode1 = forwarding_mode_control[`VFMC_OUT1_SYNC_HI:`VFMC_OUT1_SYNC_LO];
  wire [1:0] rr_en      = {forwarding_mode_control[`VFMC_BIT_OUT1_RR], forwarding_mode_control[`VFMC_BIT_OUT0_RR]};
  wire       addr_ok    = hsel & hready & htrans[1];
  wire       rd_clear   = dph_read & (dph_idx == `VFMC_IDX_FWD_STATUS);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h000000, rd_hold};
  assign irq       = |(irq_status & irq_enable);

  // Bus: writes land in the data phase; reads are presented with zero wait states
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_write <= 1'b0;
      dph_read  <= 1'b0;
      dph_idx   <= 8'h00;
    end
    else
    begin
      dph_write <= addr_ok & hwrite;
      dph_read  <= addr_ok & ~hwrite;
      dph_idx   <= haddr[9:2];
    end
  end

  always @*
  begin
    rd_word = 8'h00;
    if (addr_ok & ~hwrite)
    begin
      case (haddr[9:2])
        `VFMC_IDX_FWD_SELECT: rd_word = fwd_select;
        `VFMC_IDX_MODE_CTRL:  rd_word = forwarding_mode_control;
        `VFMC_IDX_FWD_STATUS: rd_word = {4'h0, out_sync_failure_flag, out_sync_locked};
        `VFMC_IDX_IRQ_STATUS: rd_word = {4'h0, irq_status};
        `VFMC_IDX_IRQ_ENABLE: rd_word = {4'h0, irq_enable};
        default:              rd_word = 8'h00;
      endcase
    end
  end

  // Read data must stand during the data phase, so latch the address-phase decode
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_hold <= 8'h00;
    else
      rd_hold <= rd_word;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fwd_select              <= `VFMC_RST_FWD_SELECT;
      forwarding_mode_control <= `VFMC_RST_MODE_CTRL;
      irq_enable              <= 4'h0;
    end
    else if (dph_write)
    begin
      case (dph_idx)
        `VFMC_IDX_FWD_SELECT: fwd_select <= hwdata[7:0];
        `VFMC_IDX_MODE_CTRL:  forwarding_mode_control <= hwdata[7:0];
        `VFMC_IDX_IRQ_ENABLE: irq_enable <= hwdata[3:0];
        default:              irq_enable <= irq_enable;
      endcase
    end
  end

  // Per-output engines
  genvar o;
  generate
    for (o = 0; o < 2; o = o + 1)
    begin : g_out
      wire [1:0] smode   = (o == 0) ? sync_mode0 : sync_mode1;
      wire       sync_on = (smode != `VFMC_SYNC_OFF);
      wire [3:0] enabled;
      genvar p;
      for (p = 0; p < NPORT; p = p + 1)
      begin : g_map
        // Replicate mode feeds output 1 from output 0's engine alone
        assign enabled[p] = ~fwd_select[`VFMC_FWD_DIS_LO + p] & (fwd_select[p] == o[0]) & ~(o == 1 & replicate);
      end
      wire [3:0] ready     = enabled & line_avail;
      wire       all_ready = (ready == enabled) & (enabled != 4'h0);
      wire       any_sync  = |(ready & line_is_sync);
      // Send-when-ready relaxes only long packets, never in concat mode
      wire       relax     = send_ready & (smode != `VFMC_SYNC_CONCAT) & ~any_sync;
      reg  [1:0] pick;
      reg        found;
      reg  [3:0] cand;
      reg  [1:0] base;
      integer    k;

      // Round-robin scans after the last served port; a sync round goes in port order
      always @*
      begin
        pick  = 2'h0;
        found = 1'b0;
        cand  = rr_en[o] ? ready : (relax ? ready & ~sent_mask[o] : pend[o] & ready);
        base  = rr_en[o] ? rr_ptr[o] + 2'h1 : 2'h0;
        for (k = 0; k < 4; k = k + 1)
        begin
          if (cand[(base + k[1:0]) & 2'h3] & ~found)
          begin
            pick  = (base + k[1:0]) & 2'h3;
            found = 1'b1;
          end
        end
      end

      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          rr_ptr[o]    <= 2'h3;
          cur_port[o]  <= 2'h0;
          busy[o]      <= 1'b0;
          pend[o]      <= 4'h0;
          sent_mask[o] <= 4'h0;
          out_sync_locked[o] <= 1'b0;
          frame_good[o] <= 1'b0;
        end
        else
        begin
          out_sync_locked[o] <= sync_on & ~rr_en[o] & all_ready;
          if (!sync_on)
            frame_good[o] <= 1'b0;
          else if (frame_end[o] & out_sync_locked[o])
            frame_good[o] <= 1'b1;
          if (busy[o])
          begin
            if (out_ack[o])
            begin
              busy[o] <= 1'b0;
              rr_ptr[o] <= cur_port[o];
              pend[o] <= pend[o] & ~(4'h1 << cur_port[o]);
              sent_mask[o] <= ((sent_mask[o] | (4'h1 << cur_port[o])) == enabled) ? 4'h0
                              : (sent_mask[o] | (4'h1 << cur_port[o]));
            end
          end
          else if (rr_en[o] & found)
          begin
            busy[o] <= 1'b1;
            cur_port[o] <= pick;
          end
          else if (sync_on & ~rr_en[o])
          begin
            if (pend[o] == 4'h0 & all_ready & ~relax)
              pend[o] <= enabled;
            else if (found)
            begin
              busy[o] <= 1'b1;
              cur_port[o] <= pick;
            end
          end
        end
      end

      // Concat mode without round-robin: one packet spanning the set; otherwise one packet per line
      wire own_first = busy[o] & ((smode != `VFMC_SYNC_CONCAT) | rr_en[o] | (pend[o] == enabled));
      wire own_last  = busy[o] & ((smode != `VFMC_SYNC_CONCAT) | rr_en[o] |
                                  ((pend[o] & ~(4'h1 << cur_port[o])) == 4'h0));
    end
  endgenerate

  // Replicate mirrors output 0's framing onto output 1
  always @*
  begin
    out_valid = {replicate ? busy[0] : busy[1], busy[0]};
    out_first = {replicate ? g_out[0].own_first : g_out[1].own_first, g_out[0].own_first};
    out_last  = {replicate ? g_out[0].own_last : g_out[1].own_last, g_out[0].own_last};
  end

  // Data path and line acknowledge back to the receive buffers
  integer q;
  always @*
  begin
    line_take = 4'h0;
    for (q = 0; q < NPORT; q = q + 1)
    begin
      if ((busy[0] & out_ack[0] & cur_port[0] == q[1:0]) | (busy[1] & out_ack[1] & cur_port[1] == q[1:0]))
        line_take[q] = 1'b1;
    end
    out_data[DW-1:0]    = line_data[cur_port[0]*DW +: DW];
    out_data[2*DW-1:DW] = replicate ? line_data[cur_port[0]*DW +: DW]
                                    : line_data[cur_port[1]*DW +: DW];
  end

  // Failure: lock lost mid-stream after a good frame; set wins over clear-on-read
  wire [1:0] fail_evt = frame_good & out_sync_locked & ~{g_out[1].all_ready, g_out[0].all_ready};
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_sync_failure_flag <= 2'h0;
      irq_status            <= 4'h0;
    end
    else
    begin
      out_sync_failure_flag <= (rd_clear ? 2'h0 : out_sync_failure_flag) | fail_evt;
      irq_status <= ((dph_write & dph_idx == `VFMC_IDX_IRQ_CLEAR) ? irq_status & ~hwdata[3:0] : irq_status)
                    | {fail_evt, out_sync_locked & ~g_out_lock_q};
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      g_out_lock_q <= 2'h0;
    else
      g_out_lock_q <= out_sync_locked;
  end

endmodule

// ---- dv/vfmc_checker_asserts.sv ----
// Checker for the forwarding control block, watching only its ports.
// Assumes single-word bus writes; it shadows the select and mode registers.
`timescale 1ns/10ps
module vfmc_checker (
  // Clock, reset and bus
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  // Stream
  input wire [3:0]  line_avail,
  input wire [3:0]  line_is_sync,
  input wire [3:0]  line_take,
  input wire [1:0]  out_valid,
  input wire [63:0] out_data,
  input wire [1:0]  out_ack
);
  reg  [7:0] sel;
  reg  [7:0] mode;
  reg  [7:0] waddr;
  reg        wpend;
  wire [3:0] m0 = ~sel[7:4] & ~sel[3:0];
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sel <= 8'hf0;
      mode <= 8'h03;
      wpend <= 1'b0;
      waddr <= 8'h00;
    end
    else if (hready)
    begin
      wpend <= hsel & htrans[1] & hwrite;
      waddr <= haddr[7:0];
      if (wpend && waddr == 8'h80)
        sel <= hwdata[7:0];
      if (wpend && waddr == 8'h84)
        mode <= hwdata[7:0];
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  repl_copy_a: assert property (mode[7] |-> out_valid[1] == out_valid[0] &&
    (!out_valid[0] || out_data[63:32] == out_data[31:0])) else $error("output 1 differs from output 0");
  sync_wait_a: assert property (mode[3:2] != 2'h0 && !mode[6] && out_valid[0] |->
    (line_avail & m0) == m0) else $error("sync line sent before all ports ready");
  ready_send_a: assert property (mode[3:2] == 2'h1 && mode[6] && $rose(|(line_avail & m0)) &&
    (line_is_sync & m0) == 4'h0 |->
    ##[0:16] out_valid[0]) else $error("ready line not sent");
  concat_wait_a: assert property (mode[3:2] == 2'h3 && out_valid[0] |->
    (line_avail & m0) == m0) else $error("concat line sent before all ports ready");
  off0_idle_a: assert property (!mode[0] && mode[3:2] == 2'h0 && !out_valid[0] |=> !out_valid[0])
    else $error("output 0 starts while disabled");
  off1_idle_a: assert property (!mode[1] && mode[5:4] == 2'h0 && !mode[7] && !out_valid[1] |=>
    !out_valid[1]) else $error("output 1 starts while disabled");
  dis_take_a: assert property ((line_take & sel[7:4]) == 4'h0)
    else $error("disabled port consumed");
  take_ack_a: assert property (line_take != 4'h0 |-> (out_ack & out_valid) != 2'h0)
    else $error("line consumed without accept");
endmodule

// ---- dv/vfmc_sink.sv ----
// Downstream receiver model: accepts lines on both outputs after a random wait.
// Assumes out_valid holds until accepted; marks a frame end every eight lines.
`timescale 1ns/10ps
module vfmc_sink (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Output ports of the block
  input  wire [1:0] out_valid,
  output reg  [1:0] out_ack,
  output reg  [1:0] frame_end
);
  reg [2:0] cnt [0:1];
  integer   k;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      out_ack <= 2'h0;
      frame_end <= 2'h0;
      cnt[0] <= 3'h0;
      cnt[1] <= 3'h0;
    end
    else
      for (k = 0; k < 2; k = k + 1)
      begin
        out_ack[k] <= out_valid[k] & ~out_ack[k] & (($urandom % 2) != 0);
        frame_end[k] <= out_ack[k] && cnt[k] == 3'h7;
        if (out_ack[k])
          cnt[k] <= cnt[k] + 3'h1;
      end
endmodule

// ---- dv/video_forwarding_mode_control_test.sv ----
// Testbench for the forwarding control block with a downstream receiver model.
// Assumes bus reads are answered in the data phase with no wait states.
`timescale 1ns/10ps
module video_forwarding_mode_control_test;
  reg          hclk = 1'b0;
  reg          hresetn = 1'b0;
  reg          hsel = 1'b0;
  reg  [31:0]  haddr = 32'h0;
  reg  [1:0]   htrans = 2'h0;
  reg          hwrite = 1'b0;
  reg  [31:0]  hwdata = 32'h0;
  reg  [3:0]   line_avail = 4'h0;
  reg  [3:0]   line_is_sync = 4'h0;
  reg  [127:0] line_data = 128'h00000003_00000002_00000001_00000000;
  wire [31:0]  hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         irq;
  wire [3:0]   line_take;
  wire [1:0]   out_valid, out_first, out_last, out_ack, frame_end;
  wire [63:0]  out_data;
  reg  [31:0]  rd;
  reg  [1:0]   exp_q[$];
  integer      n_fail = 0;
  integer      n_tests = 0;
  integer      cyc = 0;
  integer      w, i, j, got;
  initial forever #2.5 hclk = ~hclk;
  vfmc_forward_ctrl vfmc_forward_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_avail(line_avail), .line_is_sync(line_is_sync), .line_data(line_data),
    .line_take(line_take), .out_valid(out_valid), .out_first(out_first), .out_last(out_last),
    .out_data(out_data), .out_ack(out_ack), .frame_end(frame_end), .irq(irq));
  vfmc_sink vfmc_sink_inst (.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid), .out_ack(out_ack),
    .frame_end(frame_end));
  task check(input [31:0] got, input [31:0] exp, input [8*8-1:0] what);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Read data is taken at the edge closing the data phase
  task bus(input wr, input [7:0] a, input [7:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      check(rd, {24'h0, e}, "register");
    end
  endtask
  task idle_out0;
    begin
      repeat (20) @(posedge hclk);
      check({31'h0, out_valid[0]}, 32'h0, "held");
      line_avail <= 4'h0;
      @(posedge hclk);
    end
  endtask
  // Lines are withdrawn at the edge of the last expected accept, so no new round starts
  task run(input [3:0] av, input [15:0] seq, input integer n);
    begin
      for (w = 0; w < n; w = w + 1)
        exp_q.push_back(seq[2*w +: 2]);
      line_avail <= av;
      w = 0;
      got = 0;
      while (got < n && w < 400)
      begin
        @(posedge hclk);
        w = w + 1;
        if (out_valid[0] === 1'b1 && out_ack[0] === 1'b1)
          got = got + 1;
      end
      line_avail <= 4'h0;
      repeat (10) @(posedge hclk);
      check(exp_q.size(), 32'h0, "drained");
    end
  endtask
  // A consumed line is replaced by a fresh word that still carries its port number
  always @(posedge hclk)
  begin
    for (j = 0; j < 4; j = j + 1)
      if (line_take[j] === 1'b1)
        line_data[32*j +: 32] <= ($urandom << 2) | j;
    if (out_valid[0] === 1'b1 && out_ack[0] === 1'b1 && exp_q.size() > 0)
      check({30'h0, out_data[1:0]}, {30'h0, exp_q.pop_front()}, "port");
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  initial
  begin
    w = $urandom(32'h71c1);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(8'h84, 8'h03);
    rchk(8'h80, 8'hf0);
    rchk(8'h88, 8'h00);
    rchk(8'hb0, 8'h00);
    bus(1'b1, 8'h80, 8'hb0);
    run(4'h5, 16'h000a, 2);
    bus(1'b1, 8'h80, 8'ha0);
    run(4'h5, 16'h0088, 4);
    bus(1'b1, 8'h80, 8'ha4);
    run(4'h5, 16'h0000, 3);
    bus(1'b1, 8'h80, 8'hc0);
    for (i = 1; i < 3; i = i + 1)
    begin
      bus(1'b1, 8'h84, 8'h02 | (i << 2));
      bus(1'b1, 8'h90, 8'h01);
      line_avail <= 4'h1;
      idle_out0;
      run(4'h3, 16'h0044, 4);
      check({31'h0, irq}, 32'h1, "irq");
      bus(1'b1, 8'h94, 8'h0f);
      bus(1'b1, 8'h90, 8'h00);
      check({31'h0, irq}, 32'h0, "irq");
    end
    bus(1'b1, 8'h84, 8'h46);
    line_is_sync <= 4'h1;
    line_avail <= 4'h1;
    idle_out0;
    line_is_sync <= 4'h0;
    run(4'h1, 16'h0000, 1);
    bus(1'b1, 8'h84, 8'h4e);
    line_avail <= 4'h1;
    idle_out0;
    bus(1'b1, 8'h84, 8'h02);
    line_avail <= 4'h1;
    idle_out0;
    bus(1'b1, 8'h84, 8'h83);
    rchk(8'h84, 8'h83);
    run(4'h1, 16'h0000, 3);
    summarize;
  end
endmodule
bind vfmc_forward_ctrl vfmc_checker vfmc_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .line_avail(line_avail),
  .line_is_sync(line_is_sync),
  .line_take(line_take), .out_valid(out_valid), .out_data(out_data), .out_ack(out_ack));
